// [rtl/dacdp_pkg.sv]
// constants shared by the audio converter data path and its input queue
// assumes a single 50 MHz system clock and a simple strobe register port
// Notes on behaviour
// - fallback sample register, 16 bits, read/write, resets to zero.
// - left sample register, 16 bits, read/write, resets to zero, takes left words.
// - right sample register, 16 bits, read/write, resets to zero, takes right words.
// - interpolation raises each channel's rate by 256, filling points between samples.
// - interpolation also smooths away the noise that up-sampling creates.
// - a modulator turns each interpolated word into a one-bit serial stream.
// - control bit 8 selects format: 1 signed two's complement, 0 unsigned.
// - unsigned: FFFF top, 8000 midpoint, 7FFF just below, 0000 bottom.
// - signed: 7FFF top, 0000 midpoint, FFFF just below, 8000 bottom.
// - converter clock is the selected fast clock divided by control bits 6..0.
// - source select bit 13 low picks the undivided PLL clock.
// - divider field divides by value plus one, 1 to 128, resets to 6.
// - an empty queue at a fetch yields the fallback sample instead.
// - one word per channel is fetched every 256 converter clocks.
// - sample writes are dropped while the queue is full or the block disabled.
package dacdp_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 16;
    localparam int          DIV_W         = 7;
    localparam int          FIFO_DEPTH    = 32;
    localparam int          PHASE_W       = 8;
    localparam int          ACC_W         = 24;
    // register offsets
    localparam logic [3:0]  OFF_CONTROL   = 4'h0;
    localparam logic [3:0]  OFF_AUX       = 4'h1;
    localparam logic [3:0]  OFF_STATUS    = 4'h2;
    localparam logic [3:0]  OFF_FALLBACK  = 4'h3;
    localparam logic [3:0]  OFF_LEFT      = 4'h4;
    localparam logic [3:0]  OFF_RIGHT     = 4'h5;
    // field positions
    localparam int          CTL_ENABLE    = 15;
    localparam int          CTL_FORMAT    = 8;
    localparam int          CTL_DIV_LSB   = 0;
    localparam int          AUX_SELECT    = 13;
    localparam int          STAT_L_FULL   = 9;
    localparam int          STAT_L_EMPTY  = 8;
    localparam int          STAT_R_FULL   = 1;
    localparam int          STAT_R_EMPTY  = 0;
    // reset values and writable masks
    localparam logic [15:0] CTL_RESET     = 16'h0005;
    localparam logic [15:0] CTL_WMASK     = 16'hB17F;
    localparam logic [15:0] AUX_RESET     = 16'h0000;
    localparam logic [15:0] AUX_WMASK     = 16'h2000;
    localparam logic [15:0] SAMPLE_RESET  = 16'h0000;
    // oversampling: one fetch per full wrap of the phase counter
    localparam logic [7:0]  PHASE_LAST    = 8'hFF;
    // modulator feedback levels, full scale of a signed 16-bit word
    localparam logic signed [23:0] FB_POS = 24'sh007FFF;
    localparam logic signed [23:0] FB_NEG = -24'sh008000;
endpackage

// [rtl/dacdp_fifo_if.sv]
// handshake bundle between a channel's queue and the data path
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface dacdp_fifo_if #(parameter int WIDTH = 16);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic             full;
    logic             empty;
    modport queue (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data, full, empty);
    modport user  (output push_valid, push_data, pop_ready,
                   input push_ready, pop_valid, pop_data, full, empty);
endinterface

// [rtl/dacdp_fifo.sv]
// first-in first-out queue for one channel's sample words
// assumes push and pop share the system clock
`timescale 1ns/1ns
module dacdp_fifo
    import dacdp_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
)(
    input  wire logic  clk_sys_i,
    input  wire logic  rst_n_i,
    dacdp_fifo_if.queue q
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W-1:0] rd_ptr_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             do_push;
    logic             do_pop;

    // flags straight from the occupancy count
    assign q.full       = (count_q == CNT_FULL);
    assign q.empty      = (count_q == '0);
    assign q.push_ready = ~q.full;
    assign q.pop_valid  = ~q.empty;
    assign q.pop_data   = mem_q[rd_ptr_q];
    assign do_push      = q.push_valid & q.push_ready;
    assign do_pop       = q.pop_ready & q.pop_valid;

    // pointer and count next values; wrap is explicit since depth need not be a power of two
    always_comb
    begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d  = count_q;
        if (do_push)
            wr_ptr_d = (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
        if (do_pop)
            rd_ptr_d = (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        if (do_push && !do_pop)
            count_d = count_q + 1'b1;
        else if (do_pop && !do_push)
            count_d = count_q - 1'b1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // storage needs no reset; words are only read after being written
    always_ff @(posedge clk_sys_i)
    begin
        if (do_push)
            mem_q[wr_ptr_q] <= q.push_data;
    end
endmodule

// [rtl/dacdp_top.sv]
// stereo converter data path: registers, input queues, divider, interpolator, modulators
// assumes a 50 MHz system clock standing in for the undivided PLL clock,
// and an auxiliary oscillator arriving asynchronously on a pin
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module dacdp_top
    import dacdp_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              aux_clk_i,
    output logic                   conv_tick_o,
    output logic                   left_bit_o,
    output logic                   right_bit_o
);

    // address match, used by the write decoders and queue pushes; the read mux decodes with a case
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] ctrl_d;
    logic [DATA_W-1:0] aux_q;
    logic [DATA_W-1:0] aux_d;
    logic [DATA_W-1:0] fallback_q;
    logic [DATA_W-1:0] fallback_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] sample_rd [2];
    logic [1:0]        ch_full;
    logic [1:0]        ch_empty;
    logic [1:0]        ch_bit;
    logic              enable;
    logic              signed_fmt;
    logic [DIV_W-1:0]  div_ratio;

    assign enable     = ctrl_q[CTL_ENABLE];
    assign signed_fmt = ctrl_q[CTL_FORMAT];
    assign div_ratio  = ctrl_q[CTL_DIV_LSB +: DIV_W];

    // configuration register next values
    always_comb
    begin
        ctrl_d     = ctrl_q;
        aux_d      = aux_q;
        fallback_d = fallback_q;
        if (wr_i && hit(addr_i, OFF_CONTROL))
            ctrl_d = wdata_i & CTL_WMASK;
        if (wr_i && hit(addr_i, OFF_AUX))
            aux_d = wdata_i & AUX_WMASK;
        if (wr_i && hit(addr_i, OFF_FALLBACK))
            fallback_d = wdata_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q     <= CTL_RESET;
            aux_q      <= AUX_RESET;
            fallback_q <= SAMPLE_RESET;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            aux_q      <= aux_d;
            fallback_q <= fallback_d;
        end
    end

    // read mux; unmapped offsets read zero, answer stands one cycle only
    always_comb
    begin
        rdata_d = '0;
        if (rd_i)
        begin
            case (addr_i)
                OFF_CONTROL:  rdata_d = ctrl_q;
                OFF_AUX:      rdata_d = aux_q;
                OFF_FALLBACK: rdata_d = fallback_q;
                OFF_LEFT:     rdata_d = sample_rd[0];
                OFF_RIGHT:    rdata_d = sample_rd[1];
                OFF_STATUS:
                begin
                    rdata_d[STAT_L_FULL]  = ch_full[0];
                    rdata_d[STAT_L_EMPTY] = ch_empty[0];
                    rdata_d[STAT_R_FULL]  = ch_full[1];
                    rdata_d[STAT_R_EMPTY] = ch_empty[1];
                end
                default:      rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign rdata_o = rdata_q;

    // auxiliary oscillator pin: two-stage synchroniser, third stage for edge detection
    logic aux_s1_q;
    logic aux_s2_q;
    logic aux_s3_q;
    logic aux_rise;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            aux_s1_q <= 1'b0;
            aux_s2_q <= 1'b0;
            aux_s3_q <= 1'b0;
        end
        else
        begin
            aux_s1_q <= aux_clk_i;
            aux_s2_q <= aux_s1_q;
            aux_s3_q <= aux_s2_q;
        end
    end

    // the pin is sampled at 50 MHz, so an auxiliary source must stay below 25 MHz
    assign aux_rise = aux_s2_q & ~aux_s3_q;

    // converter clock divider, emitted as a one-cycle tick
    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] div_cnt_d;
    logic             src_tick;
    logic             conv_tick_q;
    logic             conv_tick_d;

    assign src_tick = aux_q[AUX_SELECT] ? aux_rise : 1'b1;

    always_comb
    begin
        div_cnt_d   = div_cnt_q;
        conv_tick_d = 1'b0;
        if (!enable)
            div_cnt_d = '0;
        else if (src_tick)
        begin
            // divide by field value plus one
            if (div_cnt_q >= div_ratio)
            begin
                div_cnt_d   = '0;
                conv_tick_d = 1'b1;
            end
            else
                div_cnt_d = div_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            div_cnt_q   <= '0;
            conv_tick_q <= 1'b0;
        end
        else
        begin
            div_cnt_q   <= div_cnt_d;
            conv_tick_q <= conv_tick_d;
        end
    end

    assign conv_tick_o = conv_tick_q;

    // oversampling phase; fetch on the last of every 256 converter ticks
    logic [PHASE_W-1:0] phase_q;
    logic [PHASE_W-1:0] phase_d;
    logic               fetch;

    always_comb
    begin
        phase_d = phase_q;
        if (!enable)
            phase_d = PHASE_LAST;
        else if (conv_tick_q)
            phase_d = phase_q + 1'b1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            phase_q <= PHASE_LAST;
        else
            phase_q <= phase_d;
    end

    // first fetch lands on the first tick after enable, then every 256
    assign fetch = conv_tick_q && (phase_q == PHASE_LAST);

    // per-channel queue, interpolator and modulator; channel 0 left, 1 right
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            localparam logic [ADDR_W-1:0] OFF_SAMPLE = (ch == 0) ? OFF_LEFT : OFF_RIGHT;

            dacdp_fifo_if #(.WIDTH(DATA_W)) u_qif ();

            logic [DATA_W-1:0]       sample_q;
            logic [DATA_W-1:0]       sample_d;
            logic [DATA_W-1:0]       word;
            logic [DATA_W-1:0]       offset_word;
            logic signed [15:0]      centred;
            logic signed [15:0]      target_q;
            logic signed [15:0]      target_d;
            logic signed [ACC_W-1:0] step_q;
            logic signed [ACC_W-1:0] step_d;
            logic signed [ACC_W-1:0] acc_q;
            logic signed [ACC_W-1:0] acc_d;
            logic signed [ACC_W-1:0] filt_q;
            logic signed [ACC_W-1:0] filt_d;
            logic signed [ACC_W:0]   filt_err;
            logic signed [ACC_W-1:0] mod_in;
            logic signed [ACC_W-1:0] fb;
            logic signed [ACC_W-1:0] int1_q;
            logic signed [ACC_W-1:0] int1_d;
            logic signed [ACC_W-1:0] int2_q;
            logic signed [ACC_W-1:0] int2_d;
            logic                    bit_q;
            logic                    bit_d;

            // writes reach the queue only while enabled; a full queue refuses them
            assign u_qif.push_valid = wr_i && hit(addr_i, OFF_SAMPLE) && enable;
            assign u_qif.push_data  = wdata_i;
            assign u_qif.pop_ready  = fetch;

            dacdp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
                .clk_sys_i (clk_sys_i),
                .rst_n_i   (rst_n_i),
                .q         (u_qif.queue)
            );

            // readback holds the last accepted word only
            always_comb
            begin
                sample_d = sample_q;
                if (u_qif.push_valid && u_qif.push_ready)
                    sample_d = wdata_i;
            end

            always_ff @(posedge clk_sys_i)
            begin
                if (!rst_n_i)
                    sample_q <= SAMPLE_RESET;
                else
                    sample_q <= sample_d;
            end

            assign sample_rd[ch] = sample_q;
            assign ch_full[ch]   = u_qif.full;
            assign ch_empty[ch]  = u_qif.empty;

            // source word, fallback on underrun, then format to offset binary
            assign word        = u_qif.pop_valid ? u_qif.pop_data : fallback_q;
            assign offset_word = signed_fmt ? {~word[15], word[14:0]} : word;
            // offset binary to centred signed: 8000 becomes zero, FFFF most positive
            assign centred     = signed'({~offset_word[15], offset_word[14:0]});

            // linear interpolation: 256 equal steps from the last target to the new one
            always_comb
            begin
                target_d = target_q;
                step_d   = step_q;
                acc_d    = acc_q;
                if (fetch)
                begin
                    target_d = centred;
                    acc_d    = {target_q, 8'h00};
                    step_d   = ACC_W'(signed'({centred[15], centred}) - signed'({target_q[15], target_q}));
                end
                else if (conv_tick_q)
                    acc_d = acc_q + step_q;
            end

            // one-pole low-pass trims the corners the linear steps leave behind
            assign filt_err = signed'({acc_q[ACC_W-1], acc_q}) - signed'({filt_q[ACC_W-1], filt_q});
            always_comb
            begin
                filt_d = filt_q;
                if (conv_tick_q)
                    filt_d = filt_q + ACC_W'(filt_err >>> 2);
            end

            // second-order modulator, one output bit per converter tick
            assign mod_in = ACC_W'(filt_q >>> 8);
            assign fb     = bit_q ? FB_POS : FB_NEG;
            always_comb
            begin
                int1_d = int1_q;
                int2_d = int2_q;
                bit_d  = bit_q;
                if (conv_tick_q)
                begin
                    int1_d = int1_q + mod_in - fb;
                    int2_d = int2_q + int1_d - fb;
                    bit_d  = ~int2_d[ACC_W-1];
                end
            end

            always_ff @(posedge clk_sys_i)
            begin
                if (!rst_n_i)
                begin
                    target_q <= '0;
                    step_q   <= '0;
                    acc_q    <= '0;
                    filt_q   <= '0;
                    int1_q   <= '0;
                    int2_q   <= '0;
                    bit_q    <= 1'b0;
                end
                else
                begin
                    target_q <= target_d;
                    step_q   <= step_d;
                    acc_q    <= acc_d;
                    filt_q   <= filt_d;
                    int1_q   <= int1_d;
                    int2_q   <= int2_d;
                    bit_q    <= bit_d;
                end
            end

            assign ch_bit[ch] = bit_q;
        end
    endgenerate

    // serial streams toward the reconstruction stage
    assign left_bit_o  = ch_bit[0];
    assign right_bit_o = ch_bit[1];

endmodule

// [tb/dacdp_props.sv]
// concurrent checks on the converter data path top ports
// assumes the register map of the package; bound to every top instance below
`timescale 1ns/1ns
module dacdp_props
    import dacdp_pkg::*;
(
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              aux_clk_i,
    input wire logic              conv_tick_o,
    input wire logic              left_bit_o,
    input wire logic              right_bit_o
);
    logic [15:0] ctl_q, ctl_d, aux_q, aux_d, flb_q, flb_d;
    logic [7:0]  gap_q, gap_d;
    logic        chg_q, chg_d;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // shadow registers; chg marks a tick interval disturbed by a config write
    always_comb
    begin
        ctl_d = (wr_i && addr_i == OFF_CONTROL) ? (wdata_i & CTL_WMASK) : ctl_q;
        aux_d = (wr_i && addr_i == OFF_AUX) ? (wdata_i & AUX_WMASK) : aux_q;
        flb_d = (wr_i && addr_i == OFF_FALLBACK) ? wdata_i : flb_q;
        gap_d = conv_tick_o ? 8'h01 : gap_q + 8'h01;
        chg_d = (wr_i && (addr_i == OFF_CONTROL || addr_i == OFF_AUX)) | (chg_q & ~conv_tick_o);
    end

    // shadow state, reset to the documented values
    always_ff @(posedge clk_sys_i)
    begin
        ctl_q <= rst_n_i ? ctl_d : CTL_RESET;
        aux_q <= rst_n_i ? aux_d : AUX_RESET;
        flb_q <= rst_n_i ? flb_d : SAMPLE_RESET;
        gap_q <= rst_n_i ? gap_d : 8'h00;
        chg_q <= rst_n_i ? chg_d : 1'b1;
    end

    rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside an answer");
    rd_unmapped_a: assert property (rd_i && addr_i > OFF_RIGHT |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    ctl_read_a: assert property (rd_i && addr_i == OFF_CONTROL |=> rdata_o == $past(ctl_q))
        else $error("control readback wrong");
    aux_read_a: assert property (rd_i && addr_i == OFF_AUX |=> rdata_o == $past(aux_q))
        else $error("source select readback wrong");
    fallback_read_a: assert property (rd_i && addr_i == OFF_FALLBACK |=> rdata_o == $past(flb_q))
        else $error("fallback readback wrong");
    tick_off_a: assert property ((!ctl_q[CTL_ENABLE]) [*3] |-> !conv_tick_o)
        else $error("converter tick while disabled");
    tick_gap_a: assert property (conv_tick_o && !chg_q && !aux_q[AUX_SELECT] |-> gap_q == {1'b0, ctl_q[6:0]} + 8'h01)
        else $error("converter tick spacing wrong");
    bits_hold_a: assert property (!conv_tick_o |=> $stable(left_bit_o) && $stable(right_bit_o))
        else $error("modulator bit moved without a tick");

    cover property (conv_tick_o ##1 conv_tick_o);
    cover property (rd_i && addr_i == OFF_STATUS);
    cover property ($rose(left_bit_o) && aux_q[AUX_SELECT]);
endmodule
bind dacdp_top dacdp_props u_props (.clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
                                    .aux_clk_i, .conv_tick_o, .left_bit_o, .right_bit_o);

// [tb/dacdp_host_model.sv]
// processor model that writes and reads the converter registers
// assumes callers enter op right after a rising edge; one strobe per cycle
`timescale 1ns/1ns
module dacdp_host_model
    import dacdp_pkg::*;
(
    input  wire logic              clk_sys_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] wdata_o,
    output logic                   wr_o,
    output logic                   rd_o
);
    // quiet bus from time zero
    initial
    begin
        addr_o  = 4'h0;
        wdata_o = 16'h0000;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // one bus cycle; every signal assigned once, so back-to-back ops never clash
    task automatic op(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        wr_o    <= w;
        rd_o    <= r & ~w;
        addr_o  <= a;
        wdata_o <= d;
    endtask
endmodule

// [tb/test_audio_dac_data_path.sv]
// self-checking bench for the converter data path
// assumes the host model drives the register port; aux oscillator runs free
`timescale 1ns/1ns
module test_audio_dac_data_path;
    import dacdp_pkg::*;
    logic              clk_sys_i = 1'b0;
    logic              rst_n_i   = 1'b0;
    logic              aux_clk_i = 1'b0;
    logic              rd_prev   = 1'b0;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, v, last;
    logic              wr_i, rd_i, conv_tick_o, left_bit_o, right_bit_o;
    logic [15:0]       exp_q[$], msk_q[$];
    logic [31:0]       seed = 32'd23210;
    int                num_errors = 0, tests_run = 0, g, n;

    dacdp_top dut (.clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
                   .aux_clk_i, .conv_tick_o, .left_bit_o, .right_bit_o);
    dacdp_host_model host (.clk_sys_i(clk_sys_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

    always #10 clk_sys_i = ~clk_sys_i;
    // about 15.6 MHz, unrelated in phase to the system clock
    always #32 aux_clk_i = ~aux_clk_i;

    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic compare_reg(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
        tests_run++;
        if ((got & msk) !== (exp & msk))
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_num(input int got, input int exp, input int tol);
        tests_run++;
        if (got > exp + tol || got + tol < exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        host.op(1'b1, 1'b0, a, d);
    endtask

    // the expected answer is noted before the strobe goes out
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        host.op(1'b0, 1'b1, a, 16'h0000);
    endtask

    task automatic idle(input int c);
        host.op(1'b0, 1'b0, 4'h0, 16'h0000);
        repeat (c) @(posedge clk_sys_i);
    endtask

    // cycles until the next converter tick, bounded
    task automatic next_tick(output int c);
        c = 0;
        do
        begin
            @(posedge clk_sys_i);
            c++;
        end
        while (conv_tick_o !== 1'b1 && c < 300);
    endtask

    // density of ones from a settled fallback level, in per mille
    task automatic density(input logic f, input logic [15:0] x);
        int ones;
        ones = 0;
        wr(OFF_FALLBACK, x);
        wr(OFF_CONTROL, 16'h8001 | (f ? 16'h0100 : 16'h0000));
        idle(1536);
        repeat (4096)
        begin
            @(posedge clk_sys_i);
            ones += (left_bit_o === 1'b1) + (right_bit_o === 1'b1);
        end
        compare_num(ones * 1000 / 8192, int'(x ^ (f ? 16'h8000 : 16'h0000)) * 1000 / 65536, 30);
    endtask

    // answer watcher: oldest note against the answer cycle
    always @(posedge clk_sys_i)
    begin
        if (rd_prev && exp_q.size() > 0)
            compare_reg(rdata_o, exp_q.pop_front(), msk_q.pop_front());
        rd_prev <= rd_i;
    end

    // watchdog sized well above the expected 52k cycles
    initial
    begin
        repeat (80000) @(posedge clk_sys_i);
        num_errors++;
        complete_run();
    end

    initial
    begin
        logic [15:0] vals[6] = '{16'h8000, 16'hC000, 16'h1000, 16'h0000, 16'h4000, 16'h9000};
        int          divs[3] = '{1, 5, 127};
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // reset values, status and unmapped places
        rd(OFF_CONTROL, CTL_RESET, 16'hFFFF);
        rd(OFF_AUX, AUX_RESET, 16'hFFFF);
        rd(OFF_STATUS, 16'h0101, 16'h0303);
        for (int a = 3; a < 16; a++)
            rd(a[3:0], 16'h0000, 16'hFFFF);
        // sample writes before enable are lost; unmapped write ignored
        wr(OFF_LEFT, xs());
        wr(OFF_RIGHT, xs());
        wr(4'hA, 16'hFFFF);
        rd(OFF_LEFT, 16'h0000, 16'hFFFF);
        rd(OFF_RIGHT, 16'h0000, 16'hFFFF);
        rd(4'hA, 16'h0000, 16'hFFFF);
        rd(OFF_STATUS, 16'h0101, 16'h0303);
        wr(OFF_CONTROL, 16'hFFFF);
        rd(OFF_CONTROL, 16'hB17F, 16'hFFFF);
        wr(OFF_AUX, 16'hFFFF);
        rd(OFF_AUX, 16'h2000, 16'hFFFF);
        v = xs();
        wr(OFF_FALLBACK, v);
        rd(OFF_FALLBACK, v, 16'hFFFF);
        wr(OFF_AUX, 16'h0000);
        // divider spacing from the system clock; divide 1 would exceed the rate cap
        foreach (divs[i])
        begin
            wr(OFF_CONTROL, 16'h8000 | 16'(divs[i]));
            idle(0);
            next_tick(g);
            next_tick(g);
            compare_num(g, divs[i] + 1, 0);
        end
        // aux source, divide by 1: one tick per aux rising edge, 640 cycles hold 200
        wr(OFF_AUX, 16'h2000);
        wr(OFF_CONTROL, 16'h8000);
        idle(20);
        n = 0;
        repeat (640)
        begin
            @(posedge clk_sys_i);
            n += (conv_tick_o === 1'b1);
        end
        compare_num(n, 200, 4);
        // disable before leaving the aux source, else divide by 1 runs at the full system rate
        wr(OFF_CONTROL, 16'h0005);
        wr(OFF_AUX, 16'h0000);
        // restart so the first fetch lands before the fill; 25 MHz keeps under the cap
        wr(OFF_CONTROL, 16'h8001);
        idle(8);
        for (int i = 0; i < 33; i++)
        begin
            v = xs();
            wr(OFF_LEFT, v);
            wr(OFF_RIGHT, ~v);
            if (i < 32)
                last = v;
        end
        rd(OFF_STATUS, 16'h0202, 16'h0303);
        rd(OFF_LEFT, last, 16'hFFFF);
        rd(OFF_RIGHT, ~last, 16'hFFFF);
        idle(600);
        rd(OFF_STATUS, 16'h0000, 16'h0303);
        idle(33 * 512);
        rd(OFF_STATUS, 16'h0101, 16'h0303);
        // empty queues feed the fallback level in both formats
        foreach (vals[i])
            density(i > 2, vals[i]);
        idle(4);
        complete_run();
    end
endmodule
